/* src/spsf_core.sv */
`timescale 1ns/1ps
`include "spsf_regs.svh"

module spsf_core
  import spsf_pkg::*;
#(
  parameter int BITS = `SPSF_BITS
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic ss_n_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic ctrl_wr_in,
  input wire spsf_ctrl_s ctrl_wdata_in,
  input wire logic cfg_wr_in,
  input wire spsf_cfg_s cfg_wdata_in,
  input wire logic csr_rd_in,
  input wire logic data_wr_in,
  input wire logic [BITS-1:0] data_wdata_in,
  input wire logic data_rd_in,
  input wire logic cc_irq_mask_in,
  input wire logic wait_in,
  input wire logic halt_in,
  output spsf_ctrl_s ctrl_out,
  output spsf_cfg_s cfg_out,
  output spsf_stat_s stat_out,
  output logic [BITS-1:0] data_rdata_out,
  output logic irq_out,
  output logic wake_out
);

  localparam int CW = $clog2(BITS);
  localparam logic [CW-1:0] LAST = CW'(BITS - 1);

  spsf_ctrl_s ctrl;
  spsf_cfg_s cfg;
  spsf_stat_s stat;
  logic [BITS-1:0] tx_word;
  logic [BITS-1:0] rx_buf;
  logic ss_s1;
  logic ss_s2;
  logic dt_s1;
  logic dt_s2;
  logic dt_s3;
  logic bz_s1;
  logic bz_s2;
  logic done_armed;
  logic done_rd_seen;
  logic fault_armed;
  logic coll_armed;
  logic halt_q;
  logic halt_sel_ok;
  logic link_arst;
  logic link_por;

  // Link domain state.
  logic [CW-1:0] cnt;
  logic [BITS-1:0] rx_sh;
  logic [BITS-1:0] tx_sh;
  logic [BITS-1:0] rx_word;
  logic busy_l;
  logic done_tgl;
  logic miso_q;

  // CPU side decode.
  wire cpu_ok = ~halt_in;
  wire csr_acc = cpu_ok & (csr_rd_in | cfg_wr_in);
  wire csr_rd = cpu_ok & csr_rd_in;
  wire dat_rd = cpu_ok & data_rd_in;
  wire dat_wr = cpu_ok & data_wr_in;
  wire ctl_wr = cpu_ok & ctrl_wr_in;
  wire sel_n = cfg.soft_select_mode ? cfg.soft_select_level : ss_s2;
  wire slave_on = ctrl.port_enable & ~ctrl.controller_select;
  wire fault = ctrl.controller_select & ~sel_n;
  wire done_evt = dt_s2 ^ dt_s3;
  // With phase 0 the slave may only load between bytes, while select is high.
  wire busy = bz_s2 | (~ctrl.capture_edge_select & slave_on & ~sel_n);
  wire wr_refused = dat_wr & stat.transfer_done_flag & ~done_rd_seen;
  wire wr_coll = dat_wr & ~wr_refused & busy;
  wire wr_take = dat_wr & ~wr_refused & ~busy;
  wire done_clr = done_armed & (dat_rd | (dat_wr & ~wr_refused));
  wire fault_lock = stat.mode_fault_flag & ~fault_armed;
  wire irq_evt = stat.transfer_done_flag | stat.mode_fault_flag | stat.overrun_flag;
  // The registered halt level keeps a byte running through the halt entry edge.
  wire link_run = slave_on & ~sel_n & (~halt_q | halt_sel_ok);

  // The sampling edge of SCK becomes the rising edge of the link clock.
  // Idle level and phase must not move mid-byte or this clock glitches.
  wire link_clk = sck_in ^ (ctrl.clock_idle_level ^ ctrl.capture_edge_select);
  wire [BITS-1:0] next_rx = {rx_sh[BITS-2:0], mosi_in};
  wire [BITS-1:0] tx_src = (cnt == '0) ? tx_word : tx_sh;
  wire [BITS-1:0] next_tx = {tx_src[BITS-2:0], 1'b0};

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
      dt_s3 <= 1'b0;
      bz_s1 <= 1'b0;
      bz_s2 <= 1'b0;
    end else begin
      ss_s1 <= ss_n_in;
      ss_s2 <= ss_s1;
      dt_s1 <= done_tgl;
      dt_s2 <= dt_s1;
      dt_s3 <= dt_s2;
      bz_s1 <= busy_l;
      bz_s2 <= bz_s1;
    end
  end

  // The link reset is registered so that it never glitches.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      link_arst <= 1'b1;
      link_por <= 1'b1;
    end else begin
      link_arst <= ~link_run;
      link_por <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      halt_q <= 1'b0;
      halt_sel_ok <= 1'b0;
    end else begin
      halt_q <= halt_in;
      if (halt_in & ~halt_q) begin
        halt_sel_ok <= slave_on & ~sel_n;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl <= `SPSF_CTRL_RST;
    end else if (fault) begin
      ctrl.port_enable <= 1'b0;
      ctrl.controller_select <= 1'b0;
    end else if (ctl_wr) begin
      ctrl <= ctrl_wdata_in;
      ctrl.port_enable <= ctrl_wdata_in.port_enable & ~fault_lock;
      ctrl.controller_select <= ctrl_wdata_in.controller_select & ~fault_lock;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg <= `SPSF_CFG_RST;
    end else if (cfg_wr_in & cpu_ok) begin
      cfg <= cfg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_word <= `SPSF_BYTE_RST;
      rx_buf <= `SPSF_BYTE_RST;
    end else begin
      if (wr_take) begin
        tx_word <= data_wdata_in;
      end
      if (done_evt & ~stat.transfer_done_flag) begin
        rx_buf <= rx_word;
      end
    end
  end

  // Flags: a hardware set always wins over a software clear.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stat <= `SPSF_STAT_RST;
      done_armed <= 1'b0;
      done_rd_seen <= 1'b0;
      fault_armed <= 1'b0;
      coll_armed <= 1'b0;
    end else begin
      if (done_evt) begin
        stat.transfer_done_flag <= 1'b1;
      end else if (done_clr) begin
        stat.transfer_done_flag <= 1'b0;
      end
      if (done_evt | done_clr | ~stat.transfer_done_flag) begin
        done_armed <= 1'b0;
        done_rd_seen <= 1'b0;
      end else begin
        done_armed <= done_armed | csr_acc;
        done_rd_seen <= done_rd_seen | csr_rd;
      end
      if (done_evt & stat.transfer_done_flag) begin
        stat.overrun_flag <= 1'b1;
      end else if (csr_rd) begin
        stat.overrun_flag <= 1'b0;
      end
      if (fault) begin
        stat.mode_fault_flag <= 1'b1;
        fault_armed <= 1'b0;
      end else if (fault_armed & ctl_wr) begin
        stat.mode_fault_flag <= 1'b0;
        fault_armed <= 1'b0;
      end else if (stat.mode_fault_flag & csr_rd) begin
        fault_armed <= 1'b1;
      end
      if (wr_coll) begin
        stat.write_collision_flag <= 1'b1;
        coll_armed <= 1'b0;
      end else if (coll_armed & dat_rd) begin
        stat.write_collision_flag <= 1'b0;
        coll_armed <= 1'b0;
      end else if (stat.write_collision_flag & csr_rd) begin
        coll_armed <= 1'b1;
      end
    end
  end

  // Shifting happens only on the master's edges while selected.
  always_ff @(posedge link_clk or posedge link_arst) begin
    if (link_arst) begin
      cnt <= '0;
      rx_sh <= `SPSF_BYTE_RST;
      tx_sh <= `SPSF_BYTE_RST;
      busy_l <= 1'b0;
    end else begin
      rx_sh <= next_rx;
      tx_sh <= next_tx;
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
      busy_l <= (cnt != LAST);
    end
  end

  // Separate reset keeps the toggle from faking an event on deselect.
  always_ff @(posedge link_clk or posedge link_por) begin
    if (link_por) begin
      done_tgl <= 1'b0;
      rx_word <= `SPSF_BYTE_RST;
    end else if (!link_arst && cnt == LAST) begin
      done_tgl <= ~done_tgl;
      rx_word <= next_rx;
    end
  end

  always_ff @(negedge link_clk or posedge link_arst) begin
    if (link_arst) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_sh[BITS-1];
    end
  end

  // The first bit must be on the line before the first edge of the byte.
  assign miso_out = (cnt == '0) ? tx_word[BITS-1] : miso_q;
  assign miso_oe_out = slave_on & ~sel_n & ~cfg.output_disable & ~halt_in;
  assign irq_out = ctrl.irq_enable & ~cc_irq_mask_in & irq_evt;
  assign wake_out = ctrl.irq_enable &
                    ((wait_in & irq_evt) |
                     (halt_in & halt_sel_ok & stat.transfer_done_flag));
  assign ctrl_out = ctrl;
  assign cfg_out = cfg;
  assign stat_out = stat;
  assign data_rdata_out = rx_buf;

  property p_done_set;
    @(posedge mclk_in) disable iff (!rst_n_in)
    done_evt |=> stat.transfer_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_irq_done;
    @(posedge mclk_in) disable iff (!rst_n_in)
    stat.transfer_done_flag && ctrl.irq_enable && !cc_irq_mask_in |-> irq_out;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("missing interrupt");

  property p_done_clr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    done_armed && dat_rd && !done_evt |=> !stat.transfer_done_flag;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");

  property p_wr_block;
    @(posedge mclk_in) disable iff (!rst_n_in)
    dat_wr && stat.transfer_done_flag && !done_rd_seen |=>
      tx_word == $past(tx_word) && !stat.write_collision_flag ||
      $past(stat.write_collision_flag);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("blocked write taken");

  property p_fault;
    @(posedge mclk_in) disable iff (!rst_n_in)
    fault |=> stat.mode_fault_flag && !ctrl.port_enable && !ctrl.controller_select;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");

  property p_fault_lock;
    @(posedge mclk_in) disable iff (!rst_n_in)
    stat.mode_fault_flag && !fault_armed && ctl_wr |=>
      !ctrl.port_enable && !ctrl.controller_select;
  endproperty
  a_fault_lock: assert property (p_fault_lock) else $error("enable set in fault");

  property p_fault_clr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    stat.mode_fault_flag && csr_rd && !fault ##1 ctl_wr && !fault |=>
      !stat.mode_fault_flag;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault flag stuck");

  property p_overrun;
    @(posedge mclk_in) disable iff (!rst_n_in)
    done_evt && stat.transfer_done_flag |=>
      stat.overrun_flag && rx_buf == $past(rx_buf);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_overrun_clr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    csr_rd && !done_evt |=> !stat.overrun_flag;
  endproperty
  a_overrun_clr: assert property (p_overrun_clr) else $error("overrun not cleared");

  property p_coll;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_coll |=> stat.write_collision_flag && tx_word == $past(tx_word);
  endproperty
  a_coll: assert property (p_coll) else $error("collision not handled");

  property p_coll_quiet;
    @(posedge mclk_in) disable iff (!rst_n_in)
    stat.write_collision_flag && !stat.transfer_done_flag && !stat.mode_fault_flag &&
      !stat.overrun_flag |-> !irq_out;
  endproperty
  a_coll_quiet: assert property (p_coll_quiet) else $error("stray interrupt");

  property p_halt_wake;
    @(posedge mclk_in) disable iff (!rst_n_in)
    halt_in && wake_out |-> halt_sel_ok && stat.transfer_done_flag;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("bad halt wakeup");

  property p_byte_len;
    @(posedge link_clk) disable iff (link_arst)
    cnt == LAST |=> cnt == '0 && done_tgl != $past(done_tgl);
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("byte length wrong");

  c_done: cover property (@(posedge mclk_in) disable iff (!rst_n_in) done_evt);
  c_overrun: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    done_evt && stat.transfer_done_flag);
  c_coll: cover property (@(posedge mclk_in) disable iff (!rst_n_in) wr_coll);
  c_fault: cover property (@(posedge mclk_in) disable iff (!rst_n_in) fault);

endmodule : spsf_core

/* src/spsf_pkg.sv */
package spsf_pkg;
  typedef struct packed {
    logic irq_enable;
    logic port_enable;
    logic controller_select;
    logic clock_idle_level;
    logic capture_edge_select;
  } spsf_ctrl_s;

  typedef struct packed {
    logic output_disable;
    logic soft_select_mode;
    logic soft_select_level;
  } spsf_cfg_s;

  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } spsf_stat_s;
endpackage : spsf_pkg

/* src/spsf_regs.svh */
// Overview of operation
// - In slave mode the shift clock comes from the master's SCK input.
// - A data write loads the shift register, shifted out on MISO MSB first.
// - A slave byte starts only on master clock edges carrying MOSI data.
// - Byte done sets transfer_done_flag; interrupt if irq_enable and CPU mask clear.
// - Flag clears after a control/status access then a data read or write.
// - While the done flag is set, data writes are ignored until control/status read.
// - Idle level and capture edge pick one of four timings, same at both ends.
// - Master with select low sets mode_fault_flag; interrupt if irq_enable.
// - A mode fault clears port_enable and controller_select, forcing slave mode.
// - Mode fault clears after control/status read then control register write.
// - During mode fault, enable and master bits cannot be set except clearing write.
// - A byte ending while the done flag is still set sets overrun_flag.
// - After overrun the buffer keeps the first byte; later bytes are discarded.
// - Reading control/status clears overrun_flag.
// - A data write during a transfer is discarded and sets write_collision_flag.
// - Write collision never raises an interrupt request.
// - Port runs in wait; done, fault and overrun events wake the device.
// - Halt freezes registers; only slave done wakes, if select was low at entry.
// - Idle level 0 means SCK idles low; capture select 0 captures on first edge.
// - Soft select mode makes the internal select follow the soft level.
`ifndef SPSF_REGS_SVH
`define SPSF_REGS_SVH
`define SPSF_BITS 8
`define SPSF_CTRL_RST 5'h00
`define SPSF_CFG_RST 3'h0
`define SPSF_STAT_RST 4'h0
`define SPSF_BYTE_RST 8'h00
`endif

/* verif/spsf_controller_select_model.sv */
`timescale 1ns/1ps
module spsf_link_model (
  input wire logic idle_in,
  input wire logic phase_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic ss_n_out
);
  localparam realtime HALF = 62.5;
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
  end
  task automatic sel(input logic lvl);
    ss_n_out = lvl;
  endtask : sel
  // The clock idles at the shared programmed level and only runs inside a frame.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic hold);
    sck_out = idle_in;
    #3.7;
    ss_n_out = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      if (!phase_in) begin
        mosi_out = tx[i];
        #(HALF - 1) rx[i] = miso_in;
        #1 sck_out = ~idle_in;
        #HALF sck_out = idle_in;
      end else begin
        #HALF sck_out = ~idle_in;
        mosi_out = tx[i];
        #(HALF - 1) rx[i] = miso_in;
        #1 sck_out = idle_in;
      end
    end
    #HALF;
    // Unless hold is set, select rises between bytes so that a phase 0 slave may reload its shifter.
    if (!hold) ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #HALF;
  endtask : xfer
endmodule : spsf_link_model

/* verif/tb_spsf_core.sv */
`timescale 1ns/1ps
module tb_spsf_core import spsf_pkg::*;;
  localparam logic [4:0] CTRL = 5'h01, CFG = 5'h02, CSR = 5'h04, DWR = 5'h08, DRD = 5'h10;
  logic mclk, rst_n, mask, wait_l, halt_l, m_idle, m_phase;
  logic [4:0] stb;
  logic [7:0] dwd, rdata, rx;
  spsf_ctrl_s ctrl_wd, ctrl_q;
  spsf_cfg_s cfg_wd, cfg_q;
  spsf_stat_s stat_q;
  logic miso, miso_oe, irq, wake, sck, mosi, ss_n;
  int mismatches, cmp_count;
  spsf_core i_spsf_core (.mclk_in(mclk), .rst_n_in(rst_n), .sck_in(sck), .mosi_in(mosi),
    .ss_n_in(ss_n), .miso_out(miso), .miso_oe_out(miso_oe), .ctrl_wr_in(stb[0]),
    .ctrl_wdata_in(ctrl_wd), .cfg_wr_in(stb[1]), .cfg_wdata_in(cfg_wd), .csr_rd_in(stb[2]),
    .data_wr_in(stb[3]), .data_wdata_in(dwd), .data_rd_in(stb[4]), .cc_irq_mask_in(mask),
    .wait_in(wait_l), .halt_in(halt_l), .ctrl_out(ctrl_q), .cfg_out(cfg_q), .stat_out(stat_q),
    .data_rdata_out(rdata), .irq_out(irq), .wake_out(wake));
  // A released MISO line shows the inverse, so a sample taken while undriven fails.
  spsf_link_model u_mst (.idle_in(m_idle), .phase_in(m_phase),
    .miso_in(miso_oe ? miso : ~miso), .sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic chk1(input string w, input logic s, input logic e);
    chk(w, {7'h0, s}, {7'h0, e});
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic pulse(input logic [4:0] s);
    cyc(1);
    stb = s;
    cyc(1);
    stb = 5'h00;
  endtask : pulse
  task automatic ctl(input logic ie, input logic pe, input logic ms, input logic ci,
                     input logic ph);
    ctrl_wd = '{ie, pe, ms, ci, ph};
    pulse(CTRL);
    cyc(1);
  endtask : ctl
  task automatic wait_done;
    for (int i = 0; i < 50 && stat_q.transfer_done_flag !== 1'b1; i++) cyc(1);
  endtask : wait_done
  task automatic byte_io(input logic [7:0] stx, input logic [7:0] mtx, input logic hold);
    dwd = stx;
    pulse(DWR);
    u_mst.xfer(mtx, rx, hold);
    wait_done();
  endtask : byte_io
  task automatic clr;
    pulse(CSR);
    pulse(DRD);
    cyc(1);
  endtask : clr
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      ctl(1'b1, 1'b0, 1'b0, m[1], m[0]);
      m_idle = m[1];
      m_phase = m[0];
      ctl(1'b1, 1'b1, 1'b0, m[1], m[0]);
      byte_io(8'h96 ^ 8'(m), 8'h3c + 8'(m), 1'b0);
      chk("miso_byte", rx, 8'h96 ^ 8'(m));
      chk("rx_byte", rdata, 8'h3c + 8'(m));
      chk1("done", stat_q.transfer_done_flag, 1'b1);
      chk1("irq", irq, 1'b1);
      clr();
      chk1("done_clr", stat_q.transfer_done_flag, 1'b0);
    end
  endtask : t_modes
  task automatic t_refuse;
    mask = 1'b1;
    byte_io(8'h11, 8'h22, 1'b0);
    chk1("irq_masked", irq, 1'b0);
    dwd = 8'h3c;
    pulse(DWR);
    cyc(1);
    chk1("done_kept", stat_q.transfer_done_flag, 1'b1);
    pulse(CSR);
    dwd = 8'h5a;
    pulse(DWR);
    cyc(1);
    chk1("done_wr_clr", stat_q.transfer_done_flag, 1'b0);
    mask = 1'b0;
    u_mst.xfer(8'h00, rx, 1'b0);
    wait_done();
    chk("miso_reload", rx, 8'h5a);
    clr();
  endtask : t_refuse
  task automatic t_overrun;
    byte_io(8'h00, 8'ha1, 1'b0);
    u_mst.xfer(8'hb2, rx, 1'b0);
    cyc(8);
    chk1("overrun", stat_q.overrun_flag, 1'b1);
    chk1("overrun_irq", irq, 1'b1);
    chk("overrun_keep", rdata, 8'ha1);
    pulse(CSR);
    cyc(1);
    chk1("overrun_clr", stat_q.overrun_flag, 1'b0);
    pulse(DRD);
    cyc(1);
  endtask : t_overrun
  task automatic t_collide;
    ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    m_idle = 1'b0;
    m_phase = 1'b0;
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    dwd = 8'hc3;
    pulse(DWR);
    fork
      u_mst.xfer(8'h0f, rx, 1'b0);
      begin
        #500;
        cyc(1);
        dwd = 8'hff;
        pulse(DWR);
        cyc(1);
        chk1("coll", stat_q.write_collision_flag, 1'b1);
        chk1("coll_irq", irq, 1'b0);
      end
    join
    wait_done();
    chk("coll_tx", rx, 8'hc3);
    clr();
    chk1("coll_clr", stat_q.write_collision_flag, 1'b0);
  endtask : t_collide
  task automatic t_fault;
    cfg_wd = '{1'b0, 1'b1, 1'b0};
    pulse(CFG);
    chk("cfg_soft", {5'h0, cfg_q}, 8'h02);
    ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    chk1("fault", stat_q.mode_fault_flag, 1'b1);
    chk1("fault_irq", irq, 1'b1);
    chk("fault_off", {5'h0, ctrl_q.port_enable, ctrl_q.controller_select, miso_oe}, '0);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk1("fault_pe", ctrl_q.port_enable, 1'b0);
    // Status read and control write back to back, the tightest legal clearing order.
    ctrl_wd = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    stb = CSR;
    cyc(1);
    stb = CTRL;
    cyc(1);
    stb = 5'h00;
    cyc(1);
    chk1("fault_clr", stat_q.mode_fault_flag, 1'b0);
    chk1("fault_pe2", ctrl_q.port_enable, 1'b1);
    chk1("oe_soft", miso_oe, 1'b1);
    cfg_wd = '{1'b0, 1'b0, 1'b1};
    pulse(CFG);
  endtask : t_fault
  task automatic t_power;
    wait_l = 1'b1;
    byte_io(8'h00, 8'h44, 1'b0);
    chk1("wake_wait", wake, 1'b1);
    wait_l = 1'b0;
    clr();
    u_mst.sel(1'b0);
    cyc(5);
    halt_l = 1'b1;
    u_mst.xfer(8'h55, rx, 1'b1);
    wait_done();
    chk1("wake_halt", wake, 1'b1);
    cyc(1);
    halt_l = 1'b0;
    u_mst.sel(1'b1);
    clr();
    halt_l = 1'b1;
    cyc(2);
    u_mst.xfer(8'h66, rx, 1'b0);
    cyc(10);
    chk1("wake_nosel", wake, 1'b0);
    chk1("done_frozen", stat_q.transfer_done_flag, 1'b0);
    halt_l = 1'b0;
  endtask : t_power
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial begin
    {rst_n, mask, wait_l, halt_l, m_idle, m_phase, stb, dwd} = '0;
    ctrl_wd = '0;
    cfg_wd = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk("stat_rst", {4'h0, stat_q}, 8'h00);
    chk("ctrl_rst", {3'h0, ctrl_q}, 8'h00);
    chk("cfg_rst", {5'h0, cfg_q}, 8'h00);
    chk1("oe_rst", miso_oe, 1'b0);
    t_modes();
    t_refuse();
    t_overrun();
    t_collide();
    t_fault();
    t_power();
    complete_run();
  end
endmodule : tb_spsf_core
